// file: logic/ast_pkg.sv
// Constants and types shared by the asynchronous serial transceiver
package ast_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RX_STATUS = 8'h18;
  localparam logic [7:0] IDX_TX_HOLD = 8'h19;
  localparam logic [7:0] IDX_RX_FIFO = 8'h1a;
  localparam logic [7:0] IDX_IRQ_EN = 8'h8c;
  localparam logic [7:0] IDX_TX_STATUS = 8'h98;
  localparam logic [7:0] IDX_BAUD = 8'h99;

  // Reset values
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_RX_STATUS = 8'h00;
  localparam logic [7:0] RST_TX_HOLD = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h02;
  localparam logic [7:0] RST_BAUD = 8'h00;

  // Field positions, receive status/control
  localparam int RX_SERIAL_PORT_ON_BIT = 7;
  localparam int RX_9BIT_BIT = 6;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int RX_FRAMING_FLAG_BIT = 2;
  localparam int RX_OVERRUN_FLAG_BIT = 1;
  localparam int RX_D9_BIT = 0;
  // Field positions, transmit status/control
  localparam int TX_CSRC_BIT = 7;
  localparam int TX_9BIT_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HIGH_SPEED_BAUD_SELECT_BIT = 2;
  localparam int TX_SHIFTER_EMPTY_STATUS_BIT = 1;
  localparam int TX_D9_BIT = 0;
  // Field positions, flags and enables
  localparam int IRQ_RX_BIT = 5;
  localparam int IRQ_TX_BIT = 4;

  // Timing counts in oversampling ticks and bits, and FIFO depth in entries
  localparam logic [1:0] PRESCALE_LAST = 2'd3;
  localparam logic [3:0] PHASE_LAST = 4'd15;
  localparam logic [3:0] SAMPLE_FIRST = 4'd6;
  localparam logic [3:0] SAMPLE_SECOND = 4'd7;
  localparam logic [3:0] SAMPLE_THIRD = 4'd8;
  localparam logic [3:0] TX_FRAME_8 = 4'd10;
  localparam logic [3:0] TX_FRAME_9 = 4'd11;
  localparam logic [3:0] RX_LAST_8 = 4'd7;
  localparam logic [3:0] RX_LAST_9 = 4'd8;
  localparam logic [1:0] FIFO_DEPTH = 2'd2;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ast_rx_state_t;
endpackage

// file: logic/ast_transceiver.sv
// Asynchronous serial transceiver with APB register access
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Frames are NRZ: start bit, eight or nine data bits, one stop bit.
// - Data bits are shifted out and in least significant bit first.
// - 8-bit divisor gives x16 or x64 bit-rate clock, chosen by high-speed select.
// - All asynchronous activity halts while the sleep input is high.
// - Async mode needs clocked-mode select clear and serial port on set.
// - Shifter reloads from holding buffer only after the stop bit, then at once.
// - Buffer-to-shifter move takes one cycle, then buffer-empty flag is set.
// - Buffer-empty flag ignores its enable, sets on transmit enable, clears on write.
// - Shifter-empty status is read-only, set while shifter empty, no interrupt.
// - Transmission starts with enable, buffered data and a shift clock, in any order.
// - Clearing transmit enable aborts, resets transmitter, releases the pin.
// - Ninth-bit mode sends nine data bits, ninth from the ninth-bit value.
// - Data recovery runs at 16 times the baud rate, shifter at bit rate.
// - Reception is enabled by the continuous-receive enable bit.
// - After stop bit, word enters FIFO if room, setting receive flag; its enable gates only the interrupt.
// - Receive flag is read-only, cleared when reads empty the FIFO.
// - Receive FIFO holds two entries while a third byte shifts in.
// - Third stop bit with FIFO full sets overrun and discards the word.
// - Overrun blocks FIFO loads; cleared by toggling continuous-receive enable.
// - Framing flag is set when the stop bit is sampled low.
// - Framing flag and ninth bit queue with data; reading loads next entry.
// - Receive level is majority of three samples near mid-bit.
module ast_transceiver (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ast_pkg::ADDR_W-1:0] paddr,
  input wire logic [ast_pkg::DATA_W-1:0] pwdata,
  output logic [ast_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepMode,
  input wire logic rxIn,
  output logic txOut,
  output logic txOe_n,
  output logic serialIrq
);
  import ast_pkg::*;

  typedef struct packed {
    logic [7:0] baudCnt;
    logic [1:0] prescale;
    logic [3:0] txPhase;
    logic [7:0] txHold;
    logic txHoldFull;
    logic [10:0] txShift;
    logic [3:0] txBitsLeft;
    logic txBusy;
    logic txLine;
    ast_rx_state_t rxState;
    logic [3:0] rxPhase;
    logic [3:0] rxBitIdx;
    logic [8:0] rxShift;
    logic [1:0] rxSamp;
    logic rxArmed;
    logic [1:0][9:0] fifo;
    logic fifoHead;
    logic [1:0] fifoCount;
    logic overrun;
    logic serial_port_on;
    logic rx9;
    logic continuous_receive_enable;
    logic csrc;
    logic tx9;
    logic transmit_enable;
    logic syncMode;
    logic high_speed_baud_select;
    logic transmit_ninth_bit_value;
    logic [7:0] irqEn;
    logic [7:0] baudDiv;
    logic [31:0] rdData;
  } ast_state_t;

  ast_state_t s_r;
  ast_state_t s_nxt;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  logic asyncOn;
  logic txRun;
  logic rxOn;
  logic tick;
  logic tick16;
  logic bitTick;
  logic txFlag;
  logic rxFlag;
  logic [7:0] idx;
  logic mapped;
  logic accessCycle;
  logic [9:0] headEntry;
  logic [7:0] rxStatus;
  logic [7:0] txStatus;
  logic [7:0] irqFlags;

  always_comb begin
    asyncOn = s_r.serial_port_on & ~s_r.syncMode;
    txRun = asyncOn & s_r.transmit_enable;
    rxOn = asyncOn & s_r.continuous_receive_enable;
    tick = ~sleepMode & (s_r.baudCnt == 8'h00);
    tick16 = tick & (s_r.high_speed_baud_select | (s_r.prescale == PRESCALE_LAST));
    bitTick = tick16 & (s_r.txPhase == PHASE_LAST);
    txFlag = txRun & ~s_r.txHoldFull;
    rxFlag = s_r.fifoCount != 2'd0;
    idx = paddr[9:2];
    mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
             (idx == IDX_IRQ_FLAGS || idx == IDX_RX_STATUS || idx == IDX_TX_HOLD ||
              idx == IDX_RX_FIFO || idx == IDX_IRQ_EN || idx == IDX_TX_STATUS ||
              idx == IDX_BAUD);
    accessCycle = psel & penable;
    headEntry = s_r.fifo[s_r.fifoHead];
    rxStatus = 8'h00;
    rxStatus[RX_SERIAL_PORT_ON_BIT] = s_r.serial_port_on;
    rxStatus[RX_9BIT_BIT] = s_r.rx9;
    rxStatus[RX_CONTINUOUS_RECEIVE_ENABLE_BIT] = s_r.continuous_receive_enable;
    rxStatus[RX_FRAMING_FLAG_BIT] = headEntry[9];
    rxStatus[RX_OVERRUN_FLAG_BIT] = s_r.overrun;
    rxStatus[RX_D9_BIT] = headEntry[8];
    txStatus = 8'h00;
    txStatus[TX_CSRC_BIT] = s_r.csrc;
    txStatus[TX_9BIT_BIT] = s_r.tx9;
    txStatus[TX_EN_BIT] = s_r.transmit_enable;
    txStatus[TX_SYNC_BIT] = s_r.syncMode;
    txStatus[TX_HIGH_SPEED_BAUD_SELECT_BIT] = s_r.high_speed_baud_select;
    txStatus[TX_SHIFTER_EMPTY_STATUS_BIT] = ~s_r.txBusy;
    txStatus[TX_D9_BIT] = s_r.transmit_ninth_bit_value;
    irqFlags = 8'h00;
    irqFlags[IRQ_RX_BIT] = rxFlag;
    irqFlags[IRQ_TX_BIT] = txFlag;
  end

  always_comb begin
    logic [10:0] frame;
    logic [3:0] frameLen;
    logic vote;
    logic [1:0] slot;
    frame = 11'h000;
    frameLen = 4'h0;
    vote = 1'b0;
    slot = 2'b00;
    s_nxt = s_r;

    // Baud generator, frozen in sleep
    if (!sleepMode) begin
      if (s_r.baudCnt == 8'h00) begin
        s_nxt.baudCnt = s_r.baudDiv;
        s_nxt.prescale = s_r.high_speed_baud_select ? 2'd0 : s_r.prescale + 2'd1;
      end else begin
        s_nxt.baudCnt = s_r.baudCnt - 8'h01;
      end
    end
    if (tick16) begin
      s_nxt.txPhase = s_r.txPhase + 4'd1;
    end

    // APB read data captured in the setup cycle, so prdata is a flop
    if (psel && !penable) begin
      s_nxt.rdData = 32'h0000_0000;
      unique case (idx)
        IDX_IRQ_FLAGS: s_nxt.rdData[7:0] = irqFlags;
        IDX_RX_STATUS: s_nxt.rdData[7:0] = rxStatus;
        IDX_TX_HOLD: s_nxt.rdData[7:0] = s_r.txHold;
        IDX_RX_FIFO: s_nxt.rdData[7:0] = headEntry[7:0];
        IDX_IRQ_EN: s_nxt.rdData[7:0] = s_r.irqEn;
        IDX_TX_STATUS: s_nxt.rdData[7:0] = txStatus;
        IDX_BAUD: s_nxt.rdData[7:0] = s_r.baudDiv;
        default: s_nxt.rdData = 32'h0000_0000;
      endcase
      if (!mapped) begin
        s_nxt.rdData = 32'h0000_0000;
      end
    end

    // Transmitter
    frameLen = s_r.tx9 ? TX_FRAME_9 : TX_FRAME_8;
    frame = {1'b1, s_r.tx9 ? s_r.transmit_ninth_bit_value : 1'b1, s_r.txHold, 1'b0};
    if (!txRun) begin
      s_nxt.txBusy = 1'b0;
      s_nxt.txBitsLeft = 4'h0;
      s_nxt.txLine = 1'b1;
    end else begin
      if (bitTick && s_r.txBusy && s_r.txBitsLeft != 4'h0) begin
        s_nxt.txLine = s_r.txShift[0];
        s_nxt.txShift = {1'b1, s_r.txShift[10:1]};
        s_nxt.txBitsLeft = s_r.txBitsLeft - 4'd1;
      end else if (bitTick && s_r.txBusy) begin
        s_nxt.txBusy = 1'b0;
      end
      // Reload only once the stop bit has had its full bit time
      if (s_r.txHoldFull &&
          (!s_r.txBusy || (bitTick && s_r.txBitsLeft == 4'h0))) begin
        s_nxt.txBusy = 1'b1;
        s_nxt.txHoldFull = 1'b0;
        if (bitTick) begin
          s_nxt.txLine = 1'b0;
          s_nxt.txShift = {1'b1, frame[10:1]};
          s_nxt.txBitsLeft = frameLen - 4'd1;
        end else begin
          s_nxt.txShift = frame;
          s_nxt.txBitsLeft = frameLen;
        end
      end
    end

    // Receiver data recovery at 16 ticks per bit
    if (!rxOn) begin
      s_nxt.rxState = RX_IDLE;
      s_nxt.overrun = 1'b0;
      s_nxt.rxPhase = 4'h0;
      s_nxt.rxArmed = 1'b1;
    end else if (tick16) begin
      if (s_r.rxState == RX_IDLE) begin
        if (!rxIn && s_r.rxArmed) begin
          s_nxt.rxState = RX_START;
          s_nxt.rxPhase = 4'd1;
        end else if (rxIn) begin
          s_nxt.rxArmed = 1'b1;
        end
      end else begin
        s_nxt.rxPhase = s_r.rxPhase + 4'd1;
        if (s_r.rxPhase == SAMPLE_FIRST) begin
          s_nxt.rxSamp[0] = rxIn;
        end
        if (s_r.rxPhase == SAMPLE_SECOND) begin
          s_nxt.rxSamp[1] = rxIn;
        end
        if (s_r.rxPhase == SAMPLE_THIRD) begin
          vote = maj3(s_r.rxSamp[0], s_r.rxSamp[1], rxIn);
          unique case (s_r.rxState)
            RX_START: begin
              // A start bit that votes high was a glitch
              s_nxt.rxState = vote ? RX_IDLE : RX_DATA;
              s_nxt.rxBitIdx = 4'h0;
            end
            RX_DATA: begin
              s_nxt.rxShift = {vote, s_r.rxShift[8:1]};
              s_nxt.rxBitIdx = s_r.rxBitIdx + 4'd1;
              if (s_r.rxBitIdx == (s_r.rx9 ? RX_LAST_9 : RX_LAST_8)) begin
                s_nxt.rxState = RX_STOP;
              end
            end
            RX_STOP: begin
              s_nxt.rxState = RX_IDLE;
              // Low stop bit must return high first, else its tail looks like a start
              s_nxt.rxArmed = vote;
            end
            default: s_nxt.rxState = RX_IDLE;
          endcase
        end
      end
    end

    // APB writes and the FIFO pop take effect in the access cycle
    if (accessCycle && mapped) begin
      if (pwrite) begin
        unique case (idx)
          IDX_RX_STATUS: begin
            s_nxt.serial_port_on = pwdata[RX_SERIAL_PORT_ON_BIT];
            s_nxt.rx9 = pwdata[RX_9BIT_BIT];
            s_nxt.continuous_receive_enable = pwdata[RX_CONTINUOUS_RECEIVE_ENABLE_BIT];
          end
          IDX_TX_HOLD: begin
            s_nxt.txHold = pwdata[7:0];
            s_nxt.txHoldFull = 1'b1;
          end
          IDX_IRQ_EN: s_nxt.irqEn = pwdata[7:0];
          IDX_TX_STATUS: begin
            s_nxt.csrc = pwdata[TX_CSRC_BIT];
            s_nxt.tx9 = pwdata[TX_9BIT_BIT];
            s_nxt.transmit_enable = pwdata[TX_EN_BIT];
            s_nxt.syncMode = pwdata[TX_SYNC_BIT];
            s_nxt.high_speed_baud_select = pwdata[TX_HIGH_SPEED_BAUD_SELECT_BIT];
            s_nxt.transmit_ninth_bit_value = pwdata[TX_D9_BIT];
          end
          IDX_BAUD: s_nxt.baudDiv = pwdata[7:0];
          default: s_nxt.baudDiv = s_r.baudDiv;
        endcase
      end else if (idx == IDX_RX_FIFO && s_r.fifoCount != 2'd0) begin
        s_nxt.fifoHead = ~s_r.fifoHead;
        s_nxt.fifoCount = s_r.fifoCount - 2'd1;
      end
    end

    // Stop bit: push after any pop this cycle so a read frees room first
    if (rxOn && tick16 && s_r.rxState == RX_STOP && s_r.rxPhase == SAMPLE_THIRD) begin
      if (!s_r.overrun) begin
        if (s_nxt.fifoCount == FIFO_DEPTH) begin
          s_nxt.overrun = 1'b1;
        end else begin
          slot = {1'b0, s_nxt.fifoHead} + s_nxt.fifoCount;
          s_nxt.fifo[slot[0]] = {~vote, s_r.rx9 ? s_r.rxShift[8] : 1'b0,
                                 s_r.rx9 ? s_r.rxShift[7:0] : s_r.rxShift[8:1]};
          s_nxt.fifoCount = s_nxt.fifoCount + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.rxState <= RX_IDLE;
      s_r.txLine <= 1'b1;
      s_r.txHold <= RST_TX_HOLD;
      s_r.irqEn <= RST_IRQ_EN;
      s_r.baudDiv <= RST_BAUD;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdData;
  assign pready = 1'b1;
  assign pslverr = accessCycle & ~mapped;
  assign txOut = s_r.txLine;
  assign txOe_n = ~txRun;
  assign serialIrq = (rxFlag & s_r.irqEn[IRQ_RX_BIT]) |
                     (txFlag & s_r.irqEn[IRQ_TX_BIT]);
endmodule

`default_nettype wire

// file: testbench/ast_transceiver_monitor.sv
// Port-level checks on the asynchronous serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ast_transceiver_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ast_pkg::ADDR_W-1:0] paddr,
  input wire logic [ast_pkg::DATA_W-1:0] pwdata,
  input wire logic [ast_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleepMode,
  input wire logic txOut,
  input wire logic txOe_n
);
  import ast_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence apbAcc;
    psel && penable;
  endsequence
  sequence txAbort;
    apbAcc ##0 pwrite && paddr == 12'h260 && !pwdata[5];
  endsequence
  ready_high_a: assert property (apbAcc |-> pready) else $error("pready low in access");
  err_scope_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  unmapped_err_a: assert property (apbAcc ##0 paddr == 12'h000 |-> pslverr)
    else $error("unmapped access not refused");
  err_zero_a: assert property (apbAcc ##0 !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  upper_zero_a: assert property (apbAcc ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  abort_release_a: assert property (txAbort |=> txOe_n ##1 txOut)
    else $error("abort left pin driven");
  start_hold_a: assert property ($fell(txOut) |=> (!txOut || txOe_n) [*8])
    else $error("start bit too short");
  // Three cycles of sleep let any pending tick drain first
  sleep_freeze_a: assert property (sleepMode [*3] ##0 !(psel && penable) |=> $stable(txOut))
    else $error("line moved in sleep");
endmodule
bind ast_transceiver ast_transceiver_monitor u_ast_transceiver_monitor (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleepMode(sleepMode), .txOut(txOut), .txOe_n(txOe_n));
`default_nettype wire

// file: testbench/ast_serial_peer.sv
// Remote serial peer: sends frames to the receiver and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module ast_serial_peer (
  input wire logic clk,
  input wire logic txLine,
  output logic rxLine
);
  initial rxLine = 1'b1;
  task automatic sendFrame(input int bc, input logic [8:0] d, input bit nine, input logic stopLvl);
    rxLine <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rxLine <= d[i];
      repeat (bc) @(posedge clk);
    end
    rxLine <= stopLvl;
    repeat (bc) @(posedge clk);
    rxLine <= 1'b1;
    repeat (bc) @(posedge clk);
  endtask
  // Samples mid-bit, so a clock of jitter at the start edge is harmless
  task automatic catchFrame(input int bc, input bit nine, output logic [8:0] d, output logic s);
    int n;
    n = 0;
    d = 9'h0;
    s = 1'b0;
    while (txLine !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i <= (nine ? 9 : 8); i++) begin
      repeat (bc) @(posedge clk);
      if (i == (nine ? 9 : 8)) s = txLine;
      else d[i] = txLine;
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/test_ast_transceiver.sv
// Self-checking bench for the asynchronous serial transceiver
`timescale 1ns/1ps
`default_nettype none
module test_ast_transceiver;
  import ast_pkg::*;
  logic clk, reset, psel, penable, pwrite, sleepMode, rxIn;
  logic txOut, txOe_n, serialIrq, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [8:0] fd;
  logic fs;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  ast_transceiver u_ast_transceiver (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleepMode(sleepMode), .rxIn(rxIn),
    .txOut(txOut), .txOe_n(txOe_n), .serialIrq(serialIrq));
  ast_serial_peer peer (.clk(clk), .txLine(txOut), .rxLine(rxIn));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
  endtask
  // Bit 31 of the expectation stands for the refusal flag
  task automatic rdk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    check({err, rd[30:0]}, exp);
  endtask
  task automatic resetValues();
    rdk(IDX_IRQ_FLAGS, 32'h0);
    rdk(IDX_RX_STATUS, 32'h0);
    rdk(IDX_TX_HOLD, 32'h0);
    rdk(IDX_IRQ_EN, 32'h0);
    rdk(IDX_TX_STATUS, 32'h02);
    rdk(IDX_BAUD, 32'h0);
    rdk(8'h00, 32'h8000_0000);
    check({30'h0, txOut, txOe_n}, 32'h3);
  endtask
  task automatic txSlow();
    wr(IDX_BAUD, 8'h00);
    wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_TX_STATUS, 8'h20);
    check({31'h0, txOe_n}, 32'h0);
    rdk(IDX_IRQ_FLAGS, 32'h10);
    wr(IDX_TX_HOLD, 8'ha5);
    peer.catchFrame(64, 1'b0, fd, fs);
    check({23'h0, fd}, 32'h0a5);
    check({31'h0, fs}, 32'h1);
  endtask
  task automatic txFast();
    wr(IDX_BAUD, 8'h01);
    wr(IDX_TX_STATUS, 8'h45);
    wr(IDX_TX_HOLD, 8'h3c);
    repeat (80) @(posedge clk);
    check({31'h0, txOut}, 32'h1);
    wr(IDX_TX_STATUS, 8'h65);
    peer.catchFrame(32, 1'b1, fd, fs);
    check({23'h0, fd}, 32'h13c);
    repeat (40) @(posedge clk);
    fork
      begin
        peer.catchFrame(32, 1'b1, fd, fs);
        check({23'h0, fd}, 32'h181);
        peer.catchFrame(32, 1'b1, fd, fs);
        check({23'h0, fd}, 32'h142);
      end
      begin
        wr(IDX_TX_HOLD, 8'h81);
        rdk(IDX_IRQ_FLAGS, 32'h10);
        wr(IDX_TX_HOLD, 8'h42);
        rdk(IDX_IRQ_FLAGS, 32'h00);
        rdk(IDX_TX_STATUS, 32'h65);
      end
    join
    repeat (40) @(posedge clk);
    rdk(IDX_TX_STATUS, 32'h67);
  endtask
  task automatic abortSleep();
    int n;
    n = 0;
    wr(IDX_TX_HOLD, 8'hff);
    while (txOut !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    sleepMode <= 1'b1;
    repeat (60) @(posedge clk);
    check({31'h0, txOut}, 32'h0);
    sleepMode <= 1'b0;
    wr(IDX_TX_STATUS, 8'h04);
    @(negedge clk);
    check({30'h0, txOut, txOe_n}, 32'h3);
    @(posedge clk);
  endtask
  task automatic rxPath();
    wr(IDX_RX_STATUS, 8'h90);
    wr(IDX_IRQ_EN, 8'h20);
    peer.sendFrame(32, 9'h011, 1'b0, 1'b1);
    peer.sendFrame(32, 9'h022, 1'b0, 1'b0);
    peer.sendFrame(32, 9'h033, 1'b0, 1'b1);
    check({31'h0, serialIrq}, 32'h1);
    rdk(IDX_RX_STATUS, 32'h92);
    rdk(IDX_IRQ_FLAGS, 32'h20);
    rdk(IDX_RX_FIFO, 32'h11);
    rdk(IDX_RX_STATUS, 32'h96);
    rdk(IDX_RX_FIFO, 32'h22);
    rdk(IDX_IRQ_FLAGS, 32'h00);
    check({31'h0, serialIrq}, 32'h0);
    wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_RX_STATUS, 8'hd0);
    peer.sendFrame(32, 9'h144, 1'b1, 1'b1);
    rdk(IDX_RX_STATUS, 32'hd1);
    rdk(IDX_RX_FIFO, 32'h44);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sleepMode = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    resetValues();
    txSlow();
    txFast();
    abortSleep();
    rxPath();
    complete_run();
  end
endmodule
`default_nettype wire
